/* common/user_flash_pkg.sv */
// Constants for the serial user flash store
// How it works
// RULE1 - Store holds 512 words addressed by 9 bits, 000h to 1FFh.
// RULE2 - Sector zero is 000h-0FFh, sector one is 100h-1FFh.
// RULE3 - Erase clears exactly one sector per operation.
// RULE4 - Far logic erases a sector before programming any word in it.
// RULE5 - Work on one sector leaves the other sector untouched.
// RULE6 - Internal oscillator times operations; divided by four it drives clock out. Code times operations by counting core_clk cycles.
// RULE7 - Divided clock is fixed, nominally 3.3 to 5.5 MHz, not adjustable.
// RULE8 - Program or erase request runs internal algorithm, busy until done.
// RULE9 - Far logic holds program or erase request until busy drops.
// RULE10 - Single reads and stream reads of consecutive words both work.
// RULE11 - Address clock with shift select low increments the address.
// RULE12 - Address and data use separate serial lines and shift registers.
// RULE13 - Address shift register is 9 bits, data shift register 16 bits.
// RULE14 - Address clock with shift select high shifts in address, MSB first.
// RULE15 - Read loads addressed word, then shifts out 16 bits, one per pulse.
package user_flash_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int WORDS = 512;
  localparam logic [ADDR_W-1:0] SECTOR1_BASE = 9'h100;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  // Internal oscillator is modelled as core_clk divided down
  // Half period of one core cycle puts clock out at 5 MHz, inside the range
  localparam int OSC_DIV = 1;
  localparam int OUT_DIV = 4;
  // Operation times in microseconds
  localparam int PROG_TIME_US = 100;
  localparam int ERASE_TIME_US = 500;
  localparam int CLK_MHZ = 40;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;
endpackage

/* dv/flash_props.sv */
// Port assertions for the flash store
`timescale 1ns/1ps
`default_nettype none
module flash_props #(
  parameter int PROG_CYC  = 8,
  parameter int ERASE_CYC = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic program_req,
  input wire logic erase_req,
  input wire logic data_shift_clock,
  input wire logic data_serial_out,
  input wire logic busy,
  input wire logic internal_clock_out
);
  localparam int BUSY_MAX = ERASE_CYC + 8;
  logic [3:0] idle_ff;
  logic [3:0] nxt_idle;
  logic       req;
  assign req = program_req | erase_req;
  // Cycles since the data clock pin was last high
  always_comb nxt_idle = data_shift_clock ? 4'h0
                       : idle_ff + {3'h0, idle_ff != 4'hf};
  always_ff @(posedge core_clk) idle_ff <= reset ? 4'hf : nxt_idle;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_busy_cause: assert property ($rose(busy) |-> req)
    else $error("busy without request");
  chk_busy_late: assert property ($rose(busy) |-> $past(req, 3))
    else $error("busy too early");
  chk_busy_min: assert property ($rose(busy) |-> busy[*8])
    else $error("busy too short");
  chk_busy_end: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("busy stuck");
  chk_osc_high: assert property ($rose(internal_clock_out) |->
    internal_clock_out[*4] ##1 !internal_clock_out) else $error("osc high");
  chk_osc_low: assert property ($fell(internal_clock_out) |->
    !internal_clock_out[*4] ##1 internal_clock_out) else $error("osc low");
  chk_out_cause: assert property ($changed(data_serial_out) |->
    idle_ff < 4'h8) else $error("output moved unclocked");
  chk_out_busy: assert property ($past(busy) && busy |->
    $stable(data_serial_out)) else $error("output moved while busy");
  cover property ($fell(busy) && erase_req);
  cover property ($fell(busy) && program_req);
  cover property ($changed(data_serial_out));
endmodule // flash_props
bind user_flash_block flash_props #(.PROG_CYC(PROG_CYC),
  .ERASE_CYC(ERASE_CYC)) flash_props_i (.core_clk, .reset, .program_req,
  .erase_req, .data_shift_clock, .data_serial_out, .busy,
  .internal_clock_out);
`default_nettype wire

/* dv/host_model.sv */
// Far-side user logic that sequences the flash store
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic core_clk,
  input  wire logic busy,
  input  wire logic data_serial_out,
  output var logic  addr_serial_in,
  output var logic  addr_shift_clock,
  output var logic  addr_load_select,
  output var logic  data_serial_in,
  output var logic  data_shift_clock,
  output var logic  data_load_select,
  output var logic  program_req,
  output var logic  erase_req
);
  import user_flash_pkg::*;
  initial {addr_serial_in, addr_shift_clock, addr_load_select, data_serial_in,
    data_shift_clock, data_load_select, program_req, erase_req} = 8'h00;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Four cycles per phase clears the input synchroniser
  task automatic aclk();
    addr_shift_clock = 1'b1;
    tick(4);
    addr_shift_clock = 1'b0;
    tick(4);
  endtask
  task automatic dclk();
    data_shift_clock = 1'b1;
    tick(4);
    data_shift_clock = 1'b0;
    tick(4);
  endtask
  task automatic set_addr(input logic [ADDR_W-1:0] a);
    addr_load_select = 1'b1;
    for (int i = ADDR_W - 1; i >= 0; i--) begin
      addr_serial_in = a[i];
      aclk();
    end
    addr_load_select = 1'b0;
    addr_serial_in = ~addr_serial_in;
  endtask
  task automatic read_word(output logic [DATA_W-1:0] d);
    data_load_select = 1'b1;
    dclk();
    data_load_select = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      d[i] = data_serial_out;
      if (i > 0) dclk();
    end
  endtask
  task automatic op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input bit er, output bit seen);
    set_addr(a);
    for (int i = DATA_W - 1; i >= 0 && !er; i--) begin
      data_serial_in = d[i];
      dclk();
    end
    data_serial_in = ~data_serial_in;
    erase_req = er;
    program_req = !er;
    seen = 1'b0;
    for (int n = 0; n < 60 && !(seen && busy === 1'b0); n++) begin
      tick(1);
      seen = seen | (busy === 1'b1);
    end
    program_req = 1'b0;
    erase_req = 1'b0;
    tick(4);
  endtask
endmodule // host_model
`default_nettype wire

/* dv/user_flash_block_tb.sv */
// Self-checking bench for the flash store
`timescale 1ns/1ps
`default_nettype none
module user_flash_block_tb;
  import user_flash_pkg::*;
  logic core_clk, reset, asi, asc, als, dsi, dsc, dls, preq, ereq;
  logic dso, busy, osc;
  logic [DATA_W-1:0] got;
  bit seen;
  int n_mismatch, n_compared, cyc;
  user_flash_block #(.PROG_CYC(8), .ERASE_CYC(16)) user_flash_block_i (
    .core_clk, .reset, .addr_serial_in(asi), .addr_shift_clock(asc),
    .addr_load_select(als), .data_serial_in(dsi), .data_shift_clock(dsc),
    .data_load_select(dls), .program_req(preq), .erase_req(ereq),
    .data_serial_out(dso), .busy, .internal_clock_out(osc));
  host_model host_model_i (.core_clk, .busy, .data_serial_out(dso),
    .addr_serial_in(asi), .addr_shift_clock(asc), .addr_load_select(als),
    .data_serial_in(dsi), .data_shift_clock(dsc), .data_load_select(dls),
    .program_req(preq), .erase_req(ereq));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] e, a);
    n_compared++;
    if (a !== e) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    host_model_i.set_addr(a);
    host_model_i.read_word(got);
    check(e, got);
  endtask
  task automatic op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input bit er);
    host_model_i.op(a, d, er, seen);
    check(16'h0001, {15'h0, seen});
  endtask
  task automatic t_osc();
    int k;
    logic p;
    k = 0;
    p = osc;
    repeat (160) begin
      @(posedge core_clk);
      #2;
      k += int'(osc === 1'b1 && p === 1'b0);
      p = osc;
    end
    check(16'd20, k[15:0]);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    reset = 1'b1;
    repeat (6) @(posedge core_clk);
    #2 reset = 1'b0;
    op(9'h000, 16'h0000, 1'b1);
    op(9'h1ff, 16'h0000, 1'b1);
    rd(9'h000, ERASED_WORD);
    rd(9'h1ff, ERASED_WORD);
    op(9'h0ff, 16'ha5a5, 1'b0);
    op(9'h100, 16'h1234, 1'b0);
    rd(9'h0ff, 16'ha5a5);
    host_model_i.aclk();
    host_model_i.read_word(got);
    check(16'h1234, got);
    op(9'h080, 16'h0000, 1'b1);
    rd(9'h100, 16'h1234);
    rd(9'h0ff, ERASED_WORD);
    t_osc();
    wrap_up();
  end
endmodule // user_flash_block_tb
`default_nettype wire

/* rtl/user_flash_block.sv */
// Serial user flash store with program, erase and stream read
`timescale 1ns/1ps
`default_nettype none
module user_flash_block
  import user_flash_pkg::*;
#(
  parameter int PROG_CYC  = user_flash_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = user_flash_pkg::ERASE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic addr_serial_in,
  input  wire logic addr_shift_clock,
  input  wire logic addr_load_select,
  input  wire logic data_serial_in,
  input  wire logic data_shift_clock,
  input  wire logic data_load_select,
  input  wire logic program_req,
  input  wire logic erase_req,
  output logic      data_serial_out,
  output logic      busy,
  output logic      internal_clock_out
);
  import user_flash_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_WAIT_REL} op_t;

  // Three-stage sync; change counts when stages two and three agree
  logic [2:0] as_clk_ff, as_sel_ff, as_din_ff;
  logic [2:0] ds_clk_ff, ds_sel_ff, ds_din_ff, pg_ff, er_ff;
  logic       as_clk_q_ff, ds_clk_q_ff;
  logic       as_sel_q_ff, ds_sel_q_ff, as_din_q_ff, ds_din_q_ff;
  logic       pg_q_ff, er_q_ff;

  logic [DATA_W-1:0] mem [WORDS];
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] data_ff, nxt_data;
  logic              dout_ff, nxt_dout;
  op_t               op_ff, nxt_op;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              busy_ff, nxt_busy;
  logic              osc_ff, nxt_osc;
  logic [1:0]        osc_cnt_ff, nxt_osc_cnt;
  logic              oclk_ff, nxt_oclk;
  logic [1:0]        oclk_cnt_ff, nxt_oclk_cnt;
  logic              do_prog_wr;
  logic              do_erase;
  logic              erase_hi;

  function automatic logic filt(input logic [2:0] s, input logic q);
    filt = (s[1] == s[2]) ? s[2] : q;
  endfunction

  function automatic logic in_sector(input logic [ADDR_W-1:0] a,
                                     input logic hi);
    in_sector = ((a >= SECTOR1_BASE) == hi); // RULE2
  endfunction

  logic as_clk_f, ds_clk_f, as_rise, ds_rise;
  // Select and data use the same filter stage as the clock edge, so a
  // level set together with the clock rise is taken with that rise
  logic as_sel_f, as_din_f, ds_sel_f, ds_din_f;
  assign as_sel_f = filt(as_sel_ff, as_sel_q_ff);
  assign as_din_f = filt(as_din_ff, as_din_q_ff);
  assign ds_sel_f = filt(ds_sel_ff, ds_sel_q_ff);
  assign ds_din_f = filt(ds_din_ff, ds_din_q_ff);
  assign as_clk_f = filt(as_clk_ff, as_clk_q_ff);
  assign ds_clk_f = filt(ds_clk_ff, ds_clk_q_ff);
  assign as_rise  = as_clk_f & ~as_clk_q_ff;
  assign ds_rise  = ds_clk_f & ~ds_clk_q_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      {as_clk_ff, as_sel_ff, as_din_ff} <= '0;
      {ds_clk_ff, ds_sel_ff, ds_din_ff, pg_ff, er_ff} <= '0;
      {as_clk_q_ff, ds_clk_q_ff, as_sel_q_ff, ds_sel_q_ff} <= '0;
      {as_din_q_ff, ds_din_q_ff, pg_q_ff, er_q_ff} <= '0;
    end else begin
      as_clk_ff   <= {as_clk_ff[1:0], addr_shift_clock};
      as_sel_ff   <= {as_sel_ff[1:0], addr_load_select};
      as_din_ff   <= {as_din_ff[1:0], addr_serial_in};
      ds_clk_ff   <= {ds_clk_ff[1:0], data_shift_clock};
      ds_sel_ff   <= {ds_sel_ff[1:0], data_load_select};
      ds_din_ff   <= {ds_din_ff[1:0], data_serial_in};
      pg_ff       <= {pg_ff[1:0], program_req};
      er_ff       <= {er_ff[1:0], erase_req};
      as_clk_q_ff <= as_clk_f;
      ds_clk_q_ff <= ds_clk_f;
      as_sel_q_ff <= filt(as_sel_ff, as_sel_q_ff);
      ds_sel_q_ff <= filt(ds_sel_ff, ds_sel_q_ff);
      as_din_q_ff <= filt(as_din_ff, as_din_q_ff);
      ds_din_q_ff <= filt(ds_din_ff, ds_din_q_ff);
      pg_q_ff     <= filt(pg_ff, pg_q_ff);
      er_q_ff     <= filt(er_ff, er_q_ff);
    end
  end

  // Address path: shift in MSB first, or auto-increment for streams
  always_comb begin
    nxt_addr = addr_ff;
    if (as_rise && !busy_ff) begin
      if (as_sel_f)
        nxt_addr = {addr_ff[ADDR_W-2:0], as_din_f}; // RULE14 RULE12 RULE13
      else
        nxt_addr = addr_ff + 9'h001; // RULE11 RULE10 RULE1
    end
  end

  // Data path: select high loads word, select low shifts out MSB first
  always_comb begin
    nxt_data = data_ff;
    nxt_dout = dout_ff;
    if (ds_rise && !busy_ff) begin
      if (ds_sel_f) begin
        nxt_data = mem[addr_ff]; // RULE15 RULE10
        nxt_dout = mem[addr_ff][DATA_W-1];
      end else begin
        // Serial in feeds the bottom so a program word can be shifted in
        nxt_data = {data_ff[DATA_W-2:0], ds_din_f}; // RULE15 RULE12 RULE13
        nxt_dout = data_ff[DATA_W-2];
      end
    end
  end

  // Program/erase sequencer; request must be dropped before next op
  always_comb begin
    nxt_op   = op_ff;
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    unique case (op_ff)
      ST_IDLE: begin
        if (pg_q_ff) begin
          nxt_op   = ST_PROG; // RULE8
          nxt_cnt  = CNT_W'(PROG_CYC - 1);
          nxt_busy = 1'b1;
        end else if (er_q_ff) begin
          nxt_op   = ST_ERASE; // RULE8 RULE3
          nxt_cnt  = CNT_W'(ERASE_CYC - 1);
          nxt_busy = 1'b1;
        end
      end
      ST_PROG, ST_ERASE: begin
        if (cnt_ff == '0) begin
          nxt_op   = ST_WAIT_REL;
          nxt_busy = 1'b0; // RULE8
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_WAIT_REL: begin
        // Holding the request past busy would otherwise repeat it
        if (!pg_q_ff && !er_q_ff)
          nxt_op = ST_IDLE; // RULE9
      end
    endcase
  end

  // Array writes happen at the end of the timed operation
  assign do_prog_wr = (op_ff == ST_PROG) && (cnt_ff == '0);
  assign do_erase   = (op_ff == ST_ERASE) && (cnt_ff == '0);
  assign erase_hi   = addr_ff[ADDR_W-1];

  // Flash only clears bits when programming; erase sets the sector to ones
  always_ff @(posedge core_clk) begin
    if (do_prog_wr)
      mem[addr_ff] <= mem[addr_ff] & data_ff; // RULE4
    for (int i = 0; i < WORDS; i++) begin
      if (do_erase && in_sector(ADDR_W'(i), erase_hi))
        mem[i] <= ERASED_WORD; // RULE3 RULE5
    end
  end

  // Oscillator model and its divide-by-four output
  always_comb begin
    nxt_osc_cnt  = osc_cnt_ff + 2'd1;
    nxt_osc      = osc_ff;
    if (osc_cnt_ff == 2'(OSC_DIV - 1)) begin
      nxt_osc_cnt = '0;
      nxt_osc     = ~osc_ff; // RULE6 RULE7
    end
    nxt_oclk_cnt = oclk_cnt_ff;
    nxt_oclk     = oclk_ff;
    if (nxt_osc && !osc_ff) begin
      nxt_oclk_cnt = oclk_cnt_ff + 2'd1;
      if (oclk_cnt_ff[0])
        nxt_oclk = ~oclk_ff; // RULE6
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_ff     <= ADDR_RESET;
      data_ff     <= DATA_RESET;
      dout_ff     <= 1'b0;
      op_ff       <= ST_IDLE;
      cnt_ff      <= '0;
      busy_ff     <= 1'b0;
      osc_ff      <= 1'b0;
      osc_cnt_ff  <= '0;
      oclk_ff     <= 1'b0;
      oclk_cnt_ff <= '0;
    end else begin
      addr_ff     <= nxt_addr;
      data_ff     <= nxt_data;
      dout_ff     <= nxt_dout;
      op_ff       <= nxt_op;
      cnt_ff      <= nxt_cnt;
      busy_ff     <= nxt_busy;
      osc_ff      <= nxt_osc;
      osc_cnt_ff  <= nxt_osc_cnt;
      oclk_ff     <= nxt_oclk;
      oclk_cnt_ff <= nxt_oclk_cnt;
    end
  end

  assign data_serial_out    = dout_ff;
  assign busy               = busy_ff;
  assign internal_clock_out = oclk_ff;
endmodule // user_flash_block
`default_nettype wire
